//--- cjil_cond.sv
`timescale 1ns/10ps
`default_nettype none
module cjil_cond (
	input wire logic [3:0] cc_i,
	cjil_flags_if.dst fl,
	output logic take_o
);
	always_comb begin
		case (cc_i)
			cjil_pkg::CC_NEG: take_o = fl.n; // see RULE_10
			cjil_pkg::CC_POS: take_o = !fl.n && !fl.z; // see RULE_10
			cjil_pkg::CC_POS_ZERO: take_o = !fl.n; // see RULE_10
			cjil_pkg::CC_CARRY: take_o = fl.c; // see RULE_06
			cjil_pkg::CC_NO_CARRY: take_o = !fl.c; // see RULE_11
			cjil_pkg::CC_ZERO: take_o = fl.z; // see RULE_11
			cjil_pkg::CC_NONZERO: take_o = !fl.z; // see RULE_11
			cjil_pkg::CC_OVF: take_o = fl.v; // see RULE_11
			cjil_pkg::CC_NO_OVF: take_o = !fl.v; // see RULE_11
			cjil_pkg::CC_GT: take_o = !fl.z && (fl.n == fl.v); // see RULE_07 see RULE_16
			cjil_pkg::CC_GE: take_o = fl.n == fl.v; // see RULE_07 see RULE_16
			cjil_pkg::CC_LT: take_o = fl.n != fl.v; // see RULE_08 see RULE_16
			cjil_pkg::CC_LE: take_o = fl.z || (fl.n != fl.v); // see RULE_08 see RULE_16
			cjil_pkg::CC_HS: take_o = fl.c; // see RULE_09 see RULE_16
			cjil_pkg::CC_LO: take_o = !fl.c; // see RULE_09 see RULE_16
			default: take_o = 1'b0;
		endcase
	end
endmodule : cjil_cond
`default_nettype wire

//--- cjil_cycle_cnt.sv
`timescale 1ns/10ps
`default_nettype none
module cjil_cycle_cnt #(
	parameter int W = 5
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire logic [W-1:0] val_i,
	output logic fire_o
);
	logic [W-1:0] cnt_r;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
		end else if (load_i) begin
			cnt_r <= val_i;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
		end
	end
	// High in the last cycle of an instruction
	assign fire_o = (cnt_r == {{(W-1){1'b0}}, 1'b1});
endmodule : cjil_cycle_cnt
`default_nettype wire

//--- cjil_exec.sv
// What this block does
// RULE_01 - Ones-complement opcodes B4, C4 and D4 invert A, B or a file register in 8, 8 and 6 cycles.
// RULE_02 - Ones complement and both bit-test jumps clear carry and overflow and set negative and zero from the result.
// RULE_03 - Opcode 00 loads the PC with the next address plus the sign-extended short displacement in 7 cycles.
// RULE_04 - Long jumps 89, 99, A9 and prefixed E9 add a 16-bit displacement to the next address in 9, 8, 11, 16 cycles.
// RULE_05 - A taken bit-test or conditional jump lasts two cycles longer than when not taken.
// RULE_06 - Conditional jumps are two bytes and 5 cycles when not taken, and 03 jumps on carry set.
// RULE_07 - Opcode 0E jumps on signed greater-than and 0D on signed greater-or-equal.
// RULE_08 - Opcode 09 jumps on signed less-than and 0A on signed less-or-equal.
// RULE_09 - Opcode 0B jumps on unsigned higher-or-same and 0F on unsigned lower.
// RULE_10 - Opcode 01 jumps on negative, 04 on positive and 05 on positive-or-zero.
// RULE_11 - Opcodes 07, 02, 06, 08 and 0C jump on carry clear, zero, nonzero, overflow and overflow clear.
// RULE_12 - Opcode FD copies register B into the stack pointer in 7 cycles.
// RULE_13 - Opcode F0 writes its immediate byte into the flags register in 6 cycles.
// RULE_14 - Short, long and conditional jumps and the stack pointer load leave the flags unchanged.
// RULE_15 - Opcodes 77/A7 jump when the tested bits are zero and 76/A6 when set, in 10 or 11 cycles.
// RULE_16 - Signed conditions use negative, overflow and zero; unsigned ones use carry and zero. HS (0B) and LO (0F) here test carry only.
`timescale 1ns/10ps
`default_nettype none
module cjil_exec (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic instr_valid_i,
	output logic instr_ready_o,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] op1_i,
	input wire logic [7:0] op2_i,
	input wire logic [7:0] op3_i,
	input wire logic [15:0] next_instruction_address_i,
	input wire logic [7:0] reg_a_i,
	input wire logic [7:0] reg_b_i,
	input wire logic [7:0] operand_i,
	input wire logic [15:0] register_pair_pointer_i,
	output logic done_o,
	output logic pc_load_o,
	output logic [15:0] pc_o,
	output logic wr_en_o,
	output logic [1:0] wr_sel_o,
	output logic [7:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	output logic [7:0] stack_pointer_o,
	output logic [7:0] flags_register_o
);
	typedef enum logic [0:0] {CJIL_IDLE, CJIL_EXEC} cjil_state_t;
	cjil_state_t state_r;
	logic en_r;
	logic ill_r;
	logic taken_r;
	logic [7:0] flags_r;
	logic [7:0] sp_r;
	logic accept;
	logic fire;
	logic cond_take;
	logic [4:0] cyc_nxt;
	logic legal_nxt;
	logic jump_nxt;
	logic [15:0] disp_nxt;
	logic wr_nxt;
	logic [1:0] sel_nxt;
	logic [7:0] data_nxt;
	logic fl_wr_nxt;
	logic [7:0] flags_nxt;
	logic sp_wr_nxt;
	logic [7:0] bits_val;
	// Pending results, committed in the instruction's last cycle
	logic p_jump_r;
	logic [15:0] p_pc_r;
	logic p_wr_r;
	logic p_fl_wr_r;
	logic [7:0] p_flags_r;
	logic p_sp_wr_r;
	logic [7:0] p_sp_r;

	cjil_flags_if fl_bus ();
	assign fl_bus.c = flags_r[cjil_pkg::FL_C];
	assign fl_bus.n = flags_r[cjil_pkg::FL_N];
	assign fl_bus.z = flags_r[cjil_pkg::FL_Z];
	assign fl_bus.v = flags_r[cjil_pkg::FL_V];

	cjil_cond u_cond (
		.cc_i(opcode_i[3:0]),
		.fl(fl_bus),
		.take_o(cond_take)
	);

	cjil_cycle_cnt #(.W(cjil_pkg::CNT_W)) u_cnt (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.load_i(accept),
		.val_i(cyc_nxt),
		.fire_o(fire)
	);

	assign instr_ready_o = en_r && (state_r == CJIL_IDLE);
	assign accept = instr_ready_o && instr_valid_i;
	assign bits_val = operand_i & op1_i;

	// Flags after a logic result: C and V cleared, N and Z from value
	function automatic logic [7:0] cjil_logic_flags(input logic [7:0] old, input logic [7:0] res);
		logic [7:0] f;
		f = old;
		f[cjil_pkg::FL_C] = 1'b0;
		f[cjil_pkg::FL_V] = 1'b0;
		f[cjil_pkg::FL_N] = res[7];
		f[cjil_pkg::FL_Z] = (res == 8'h00);
		return f;
	endfunction : cjil_logic_flags

	always_comb begin
		cyc_nxt = cjil_pkg::CYC_ILLEGAL;
		legal_nxt = 1'b1;
		jump_nxt = 1'b0;
		disp_nxt = {{8{op1_i[7]}}, op1_i};
		wr_nxt = 1'b0;
		sel_nxt = cjil_pkg::DST_A;
		data_nxt = 8'h00;
		fl_wr_nxt = 1'b0;
		flags_nxt = flags_r;
		sp_wr_nxt = 1'b0;
		case (opcode_i)
			cjil_pkg::OP_CPL_A, cjil_pkg::OP_CPL_B, cjil_pkg::OP_CPL_FREG: begin
				wr_nxt = 1'b1; // see RULE_01
				if (opcode_i == cjil_pkg::OP_CPL_A) begin
					sel_nxt = cjil_pkg::DST_A;
					data_nxt = ~reg_a_i;
					cyc_nxt = cjil_pkg::CYC_CPL_AB;
				end else if (opcode_i == cjil_pkg::OP_CPL_B) begin
					sel_nxt = cjil_pkg::DST_B;
					data_nxt = ~reg_b_i;
					cyc_nxt = cjil_pkg::CYC_CPL_AB;
				end else begin
					sel_nxt = cjil_pkg::DST_FREG;
					data_nxt = ~operand_i;
					cyc_nxt = cjil_pkg::CYC_CPL_FREG;
				end
				fl_wr_nxt = 1'b1;
				flags_nxt = cjil_logic_flags(flags_r, data_nxt); // see RULE_02
			end
			cjil_pkg::OP_SJ: begin
				jump_nxt = 1'b1; // see RULE_03
				cyc_nxt = cjil_pkg::CYC_SJ;
			end
			cjil_pkg::OP_LJ_DIR: begin
				jump_nxt = 1'b1; // see RULE_04
				disp_nxt = {op1_i, op2_i};
				cyc_nxt = cjil_pkg::CYC_LJ_DIR;
			end
			cjil_pkg::OP_LJ_IND: begin
				jump_nxt = 1'b1; // see RULE_04
				disp_nxt = register_pair_pointer_i;
				cyc_nxt = cjil_pkg::CYC_LJ_IND;
			end
			cjil_pkg::OP_LJ_IDX: begin
				jump_nxt = 1'b1; // see RULE_04
				disp_nxt = {op1_i, op2_i} + {8'h00, reg_b_i};
				cyc_nxt = cjil_pkg::CYC_LJ_IDX;
			end
			cjil_pkg::OP_PREFIX: begin
				// Only the long-jump form of the prefix belongs here
				if (op1_i == cjil_pkg::OP_LJ_OFS) begin
					jump_nxt = 1'b1; // see RULE_04
					disp_nxt = register_pair_pointer_i + {{8{op2_i[7]}}, op2_i};
					cyc_nxt = cjil_pkg::CYC_LJ_OFS;
				end else begin
					legal_nxt = 1'b0;
				end
			end
			cjil_pkg::OP_BIT_CLR_R, cjil_pkg::OP_BIT_CLR_P, cjil_pkg::OP_BIT_SET_R, cjil_pkg::OP_BIT_SET_P: begin
				// Mask in op1, address in op2, displacement in op3
				disp_nxt = {{8{op3_i[7]}}, op3_i};
				if (opcode_i[0]) begin
					jump_nxt = (bits_val == 8'h00); // see RULE_15
				end else begin
					jump_nxt = (bits_val != 8'h00); // see RULE_15
				end
				cyc_nxt = (opcode_i[7:4] == 4'h7) ? cjil_pkg::CYC_BIT_R : cjil_pkg::CYC_BIT_P;
				if (jump_nxt) begin
					cyc_nxt = cyc_nxt + cjil_pkg::CYC_TAKEN_EXTRA; // see RULE_05
				end
				fl_wr_nxt = 1'b1;
				flags_nxt = cjil_logic_flags(flags_r, bits_val); // see RULE_02
			end
			cjil_pkg::OP_SP_LOAD: begin
				sp_wr_nxt = 1'b1; // see RULE_12
				cyc_nxt = cjil_pkg::CYC_SP_LOAD;
			end
			cjil_pkg::OP_FLAGS_LOAD: begin
				fl_wr_nxt = 1'b1; // see RULE_13
				flags_nxt = op1_i;
				cyc_nxt = cjil_pkg::CYC_FLAGS_LOAD;
			end
			default: begin
				if (opcode_i <= cjil_pkg::OP_JCND_LAST) begin
					jump_nxt = cond_take; // see RULE_06
					cyc_nxt = cond_take ? cjil_pkg::CYC_JCND + cjil_pkg::CYC_TAKEN_EXTRA : cjil_pkg::CYC_JCND; // see RULE_05
				end else begin
					legal_nxt = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_r <= CJIL_IDLE;
		end else if (accept) begin
			state_r <= CJIL_EXEC;
		end else if (fire) begin
			state_r <= CJIL_IDLE;
		end
	end

	// Latch decoded results at accept; operands may change afterwards
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			p_jump_r <= 1'b0;
			p_pc_r <= 16'h0000;
			p_wr_r <= 1'b0;
			p_fl_wr_r <= 1'b0;
			p_flags_r <= cjil_pkg::FLAGS_RST;
			p_sp_wr_r <= 1'b0;
			p_sp_r <= cjil_pkg::SP_RST;
			wr_sel_o <= cjil_pkg::DST_A;
			wr_addr_o <= 8'h00;
			wr_data_o <= 8'h00;
			ill_r <= 1'b0;
		end else if (accept) begin
			p_jump_r <= jump_nxt;
			p_pc_r <= next_instruction_address_i + disp_nxt; // see RULE_03 see RULE_04
			p_wr_r <= wr_nxt;
			p_fl_wr_r <= fl_wr_nxt;
			p_flags_r <= flags_nxt;
			p_sp_wr_r <= sp_wr_nxt;
			p_sp_r <= reg_b_i; // see RULE_12
			wr_sel_o <= sel_nxt;
			wr_addr_o <= op1_i;
			wr_data_o <= data_nxt;
			ill_r <= !legal_nxt;
		end
	end

	// Commit in the last cycle
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			done_o <= 1'b0;
			pc_load_o <= 1'b0;
			wr_en_o <= 1'b0;
			pc_o <= 16'h0000;
			taken_r <= 1'b0;
		end else begin
			done_o <= (state_r == CJIL_EXEC) && fire;
			pc_load_o <= (state_r == CJIL_EXEC) && fire && p_jump_r;
			wr_en_o <= (state_r == CJIL_EXEC) && fire && p_wr_r;
			if ((state_r == CJIL_EXEC) && fire) begin
				taken_r <= p_jump_r;
				if (p_jump_r) begin
					pc_o <= p_pc_r;
				end
			end
		end
	end

	// Flags change only where a flag write was decoded
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			flags_r <= cjil_pkg::FLAGS_RST;
		end else if ((state_r == CJIL_EXEC) && fire && p_fl_wr_r) begin
			flags_r <= p_flags_r; // see RULE_14
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sp_r <= cjil_pkg::SP_RST;
		end else if ((state_r == CJIL_EXEC) && fire && p_sp_wr_r) begin
			sp_r <= p_sp_r; // see RULE_12
		end
	end

	assign stack_pointer_o = sp_r;
	assign flags_register_o = flags_r;

	// APB slave, zero wait states
	assign pready = 1'b1;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			en_r <= cjil_pkg::CTRL_EN_RST;
		end else if (psel && penable && pwrite && (paddr == cjil_pkg::ADDR_CTRL)) begin
			en_r <= pwdata[cjil_pkg::CTRL_EN];
		end
	end

	always_comb begin
		prdata = 32'h0000_0000;
		pslverr = 1'b0;
		case (paddr)
			cjil_pkg::ADDR_CTRL: prdata[cjil_pkg::CTRL_EN] = en_r;
			cjil_pkg::ADDR_STATUS: begin
				prdata[cjil_pkg::STAT_BUSY] = (state_r == CJIL_EXEC);
				prdata[cjil_pkg::STAT_ILL] = ill_r;
				prdata[cjil_pkg::STAT_TAKEN] = taken_r;
				prdata[cjil_pkg::STAT_FL_LSB +: 8] = flags_r;
			end
			cjil_pkg::ADDR_PC: prdata[15:0] = pc_o;
			cjil_pkg::ADDR_SP: prdata[7:0] = sp_r;
			default: pslverr = psel && penable;
		endcase
	end
endmodule : cjil_exec
`default_nettype wire

//--- cjil_exec_props.sv
`timescale 1ns/10ps
`default_nettype none
module cjil_exec_props (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire logic instr_ready_o,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] op1_i,
	input wire logic [15:0] next_instruction_address_i,
	input wire logic [7:0] reg_a_i,
	input wire logic [7:0] reg_b_i,
	input wire logic done_o,
	input wire logic pc_load_o,
	input wire logic [15:0] pc_o,
	input wire logic wr_en_o,
	input wire logic [7:0] wr_data_o,
	input wire logic [7:0] stack_pointer_o,
	input wire logic [7:0] flags_register_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic acc;
	logic [7:0] op_r;
	logic [15:0] tgt_r;
	assign acc = instr_valid_i && instr_ready_o;
	// Inputs only count at accept, so keep them
	always_ff @(posedge core_clk_i) begin
		if (acc) begin
			op_r <= opcode_i;
			tgt_r <= next_instruction_address_i + {{8{op1_i[7]}}, op1_i};
		end
	end
	done_pulse_a:
		assert property (done_o |=> !done_o) else $error("done too long");
	busy_a:
		assert property (acc |=> !instr_ready_o) else $error("ready while busy");
	cond_time_a:
		assert property (acc && opcode_i inside {[8'h01:8'h0F]} |=> (!done_o) [*5] ##1
			((done_o && !pc_load_o) or ((!done_o) [*2] ##1 (done_o && pc_load_o))))
			else $error("cond jump timing");
	short_jump_a:
		assert property (acc && opcode_i == 8'h00 |-> ##8 pc_load_o && pc_o == tgt_r)
			else $error("short jump target");
	invert_a_a:
		assert property (acc && opcode_i == 8'hB4 |-> ##9 wr_en_o && wr_data_o == ~$past(reg_a_i, 9))
			else $error("invert result");
	sp_load_a:
		assert property (acc && opcode_i == 8'hFD |-> ##8 done_o && stack_pointer_o == $past(reg_b_i, 8))
			else $error("sp load");
	flags_load_a:
		assert property (acc && opcode_i == 8'hF0 |-> ##7 done_o && flags_register_o == $past(op1_i, 7))
			else $error("flags load");
	flags_keep_a:
		assert property (done_o && op_r <= 8'h0F |-> $stable(flags_register_o)) else $error("flags moved");
	pc_hold_a:
		assert property (!pc_load_o |-> $stable(pc_o)) else $error("pc moved");
	cover property (acc && opcode_i == 8'h03);
	cover property (pc_load_o && op_r == 8'h0E);
	cover property (done_o && op_r == 8'hA7);
endmodule : cjil_exec_props
`default_nettype wire

//--- cjil_exec_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cjil_exec_tb;
	logic core_clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, e;
	logic instr_valid_i, instr_ready_o, done_o, pc_load_o, wr_en_o;
	logic [1:0] wr_sel_o;
	logic [7:0] paddr, opcode_i, op1_i, op2_i, op3_i, reg_a_i, reg_b_i, operand_i;
	logic [7:0] wr_addr_o, wr_data_o, stack_pointer_o, flags_register_o;
	logic [15:0] next_instruction_address_i, register_pair_pointer_i, pc_o, n;
	logic [31:0] pwdata, prdata, q;
	int num_errors, check_count, cycles;
	cjil_exec cjil_exec_inst (.core_clk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .instr_valid_i, .instr_ready_o, .opcode_i, .op1_i, .op2_i,
		.op3_i, .next_instruction_address_i, .reg_a_i, .reg_b_i, .operand_i,
		.register_pair_pointer_i, .done_o, .pc_load_o, .pc_o, .wr_en_o, .wr_sel_o, .wr_addr_o,
		.wr_data_o, .stack_pointer_o, .flags_register_o);
	cjil_fetch_model cjil_fetch_model_inst (.core_clk_i, .instr_ready_i(instr_ready_o),
		.done_i(done_o), .wr_en_i(wr_en_o), .wr_sel_i(wr_sel_o), .wr_data_i(wr_data_o),
		.instr_valid_o(instr_valid_i), .opcode_o(opcode_i), .op1_o(op1_i), .op2_o(op2_i),
		.op3_o(op3_i), .nia_o(next_instruction_address_i), .reg_a_o(reg_a_i), .reg_b_o(reg_b_i),
		.operand_o(operand_i), .pair_o(register_pair_pointer_i));
	task automatic results;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] g, x);
		check_count++;
		if (g !== x) begin
			num_errors++;
			$display("ERROR %0t: got %h want %h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		do @(posedge core_clk_i); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic go(input logic [7:0] op, o1, o2, o3, input logic [15:0] p);
		cjil_fetch_model_inst.run(op, o1, o2, o3, p, n);
	endtask : go
	task automatic setfl(input logic [7:0] f);
		go(8'hF0, f, 8'h00, 8'h00, 16'h0);
		chk(16'(flags_register_o), 16'(f));
	endtask : setfl
	function automatic logic tk(input logic [3:0] cc, input logic [3:0] f);
		logic c, s, z, v;
		{c, s, z, v} = f;
		case (cc)
			4'h1: tk = s;
			4'h2: tk = z;
			4'h3: tk = c;
			4'h4: tk = !s && !z;
			4'h5: tk = !s;
			4'h6: tk = !z;
			4'h7: tk = !c;
			4'h8: tk = v;
			4'h9: tk = s ^ v;
			4'hA: tk = z || (s ^ v);
			4'hB: tk = c;
			4'hC: tk = !v;
			4'hD: tk = !(s ^ v);
			4'hE: tk = !z && !(s ^ v);
			default: tk = !c;
		endcase
	endfunction : tk
	task automatic icase(input logic [7:0] op, o1, d, input logic [15:0] cy, input logic [1:0] s,
		input logic [3:0] fl);
		go(op, o1, 8'h00, 8'h00, 16'h0);
		chk(n, cy);
		chk(16'({wr_en_o, wr_sel_o, wr_data_o}), 16'({1'b1, s, d}));
		chk(16'(flags_register_o[7:4]), 16'(fl));
	endtask : icase
	task automatic jcase(input logic [7:0] op, o1, o2, input logic [15:0] cy, x);
		go(op, o1, o2, 8'h00, 16'h1000);
		chk(n, cy);
		chk(16'(pc_load_o), 16'h1);
		chk(pc_o, x);
		chk(16'(flags_register_o), 16'hA5);
	endtask : jcase
	task automatic bcase(input logic [7:0] op, m, input logic [15:0] cy, input logic t, input logic [3:0] fl);
		go(op, m, 8'h00, 8'h08, 16'h3000);
		chk(n, cy);
		chk(16'(pc_load_o), 16'(t));
		if (t) chk(pc_o, 16'h3008);
		chk(16'(flags_register_o[7:4]), 16'(fl));
	endtask : bcase
	task automatic t_reset;
		chk(16'({flags_register_o, stack_pointer_o}), 16'h0001);
		apb(1'b0, 8'h10, 32'h0);
		chk(16'({e, q[7:0]}), 16'h100);
		$display("test reset done");
	endtask : t_reset
	task automatic t_inv;
		cjil_fetch_model_inst.regs(8'h0F, 8'hFF, 8'h5A, 16'h0);
		setfl(8'h90);
		icase(8'hB4, 8'h00, 8'hF0, 16'h8, 2'h0, 4'h4);
		icase(8'hC4, 8'h00, 8'h00, 16'h8, 2'h1, 4'h2);
		icase(8'hD4, 8'h33, 8'hA5, 16'h6, 2'h2, 4'h4);
		chk(16'(wr_addr_o), 16'h33);
		$display("test invert done");
	endtask : t_inv
	task automatic t_jmp;
		cjil_fetch_model_inst.regs(8'h00, 8'h05, 8'h00, 16'h0100);
		setfl(8'hA5);
		jcase(8'h00, 8'hF0, 8'h00, 16'h7, 16'h0FF0);
		jcase(8'h89, 8'h12, 8'h34, 16'h9, 16'h2234);
		jcase(8'h99, 8'h00, 8'h00, 16'h8, 16'h1100);
		jcase(8'hA9, 8'h00, 8'h10, 16'hB, 16'h1015);
		jcase(8'hF4, 8'hE9, 8'hFE, 16'h10, 16'h10FE);
		apb(1'b0, 8'h08, 32'h0);
		chk(q[15:0], 16'h10FE);
		apb(1'b0, 8'h04, 32'h0);
		chk(q[15:0], 16'hA504);
		$display("test jump done");
	endtask : t_jmp
	task automatic t_bit;
		cjil_fetch_model_inst.regs(8'h00, 8'h00, 8'hA4, 16'h0);
		setfl(8'h90);
		bcase(8'h77, 8'h03, 16'hC, 1'b1, 4'h2);
		bcase(8'h77, 8'h04, 16'hA, 1'b0, 4'h0);
		bcase(8'h76, 8'h80, 16'hC, 1'b1, 4'h4);
		bcase(8'hA7, 8'h01, 16'hD, 1'b1, 4'h2);
		bcase(8'hA6, 8'h01, 16'hB, 1'b0, 4'h2);
		$display("test bit jump done");
	endtask : t_bit
	task automatic t_cond;
		logic t;
		cjil_fetch_model_inst.stall = 2;
		for (int f = 0; f < 16; f++) begin
			setfl({4'(f), 4'h0});
			for (int c = 1; c < 16; c++) begin
				t = tk(4'(c), 4'(f));
				go(8'(c), 8'h10, 8'h00, 8'h00, 16'h2000);
				chk(n, t ? 16'h7 : 16'h5);
				chk(16'(pc_load_o), 16'(t));
				if (t) chk(pc_o, 16'h2010);
				chk(16'(flags_register_o), {8'h00, 4'(f), 4'h0});
			end
		end
		cjil_fetch_model_inst.stall = 0;
		$display("test cond done");
	endtask : t_cond
	task automatic t_sp;
		cjil_fetch_model_inst.regs(8'h00, 8'h7E, 8'h00, 16'h0);
		setfl(8'h5A);
		go(8'hFD, 8'h00, 8'h00, 8'h00, 16'h0);
		chk(n, 16'h7);
		chk(16'({stack_pointer_o, flags_register_o}), 16'h7E5A);
		apb(1'b1, 8'h0C, 32'hFF);
		apb(1'b0, 8'h0C, 32'h0);
		chk(q[15:0], 16'h7E);
		apb(1'b1, 8'h00, 32'h0);
		@(negedge core_clk_i);
		chk(16'(instr_ready_o), 16'h0);
		apb(1'b1, 8'h00, 32'h1);
		go(8'h10, 8'h00, 8'h00, 8'h00, 16'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk({n[3:0], 10'h0, q[1:0]}, 16'h1002);
		$display("test sp and bus done");
	endtask : t_sp
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	// Ceiling is several times the planned run
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles > 20000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		{rst_n_i, psel, penable, pwrite, paddr, pwdata} = '0;
		{num_errors, check_count, cycles} = '0;
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_inv();
		t_jmp();
		t_bit();
		t_cond();
		t_sp();
		results();
	end
endmodule : cjil_exec_tb
bind cjil_exec cjil_exec_props cjil_exec_props_inst (.core_clk_i, .rst_n_i, .instr_valid_i,
	.instr_ready_o, .opcode_i, .op1_i, .next_instruction_address_i, .reg_a_i, .reg_b_i, .done_o,
	.pc_load_o, .pc_o, .wr_en_o, .wr_data_o, .stack_pointer_o, .flags_register_o);
`default_nettype wire

//--- cjil_fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
module cjil_fetch_model (
	input wire logic core_clk_i,
	input wire logic instr_ready_i,
	input wire logic done_i,
	input wire logic wr_en_i,
	input wire logic [1:0] wr_sel_i,
	input wire logic [7:0] wr_data_i,
	output logic instr_valid_o,
	output logic [7:0] opcode_o,
	output logic [7:0] op1_o,
	output logic [7:0] op2_o,
	output logic [7:0] op3_o,
	output logic [15:0] nia_o,
	output logic [7:0] reg_a_o,
	output logic [7:0] reg_b_o,
	output logic [7:0] operand_o,
	output logic [15:0] pair_o
);
	int stall;
	initial begin
		stall = 0;
		instr_valid_o = 1'b0;
		{opcode_o, op1_o, op2_o, op3_o, nia_o} = '0;
		{reg_a_o, reg_b_o, operand_o, pair_o} = '0;
	end
	always @(posedge core_clk_i) begin
		if (wr_en_i) begin
			case (wr_sel_i)
				2'h0: reg_a_o <= wr_data_i;
				2'h1: reg_b_o <= wr_data_i;
				default: operand_o <= wr_data_i;
			endcase
		end
	end
	task automatic regs(input logic [7:0] a, b, o, input logic [15:0] p);
		@(posedge core_clk_i);
		{reg_a_o, reg_b_o, operand_o, pair_o} <= {a, b, o, p};
	endtask : regs
	task automatic run(input logic [7:0] op, o1, o2, o3, input logic [15:0] nia, output logic [15:0] n);
		repeat (stall) @(posedge core_clk_i);
		@(posedge core_clk_i);
		instr_valid_o <= 1'b1;
		{opcode_o, op1_o, op2_o, op3_o, nia_o} <= {op, o1, o2, o3, nia};
		@(negedge core_clk_i);
		while (instr_ready_i !== 1'b1) @(negedge core_clk_i);
		@(posedge core_clk_i);
		instr_valid_o <= 1'b0;
		// Stale bytes would hide late sampling
		{opcode_o, op1_o, op2_o, op3_o, nia_o} <= ~{op, o1, o2, o3, nia};
		// Done shows after edge N, so the first negedge counts as zero
		n = 16'h0;
		@(negedge core_clk_i);
		while (done_i !== 1'b1 && n < 16'h40) begin
			@(negedge core_clk_i);
			n++;
		end
	endtask : run
endmodule : cjil_fetch_model
`default_nettype wire

//--- cjil_flags_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cjil_flags_if;
	logic c;
	logic n;
	logic z;
	logic v;
	modport src (output c, n, z, v);
	modport dst (input c, n, z, v);
endinterface : cjil_flags_if
`default_nettype wire

//--- cjil_pkg.sv
package cjil_pkg;
	// Opcodes
	localparam logic [7:0] OP_CPL_A = 8'hB4;
	localparam logic [7:0] OP_CPL_B = 8'hC4;
	localparam logic [7:0] OP_CPL_FREG = 8'hD4;
	localparam logic [7:0] OP_SJ = 8'h00;
	localparam logic [7:0] OP_LJ_DIR = 8'h89;
	localparam logic [7:0] OP_LJ_IND = 8'h99;
	localparam logic [7:0] OP_LJ_IDX = 8'hA9;
	localparam logic [7:0] OP_PREFIX = 8'hF4;
	localparam logic [7:0] OP_LJ_OFS = 8'hE9;
	localparam logic [7:0] OP_JCND_LAST = 8'h0F;
	localparam logic [7:0] OP_BIT_CLR_R = 8'h77;
	localparam logic [7:0] OP_BIT_CLR_P = 8'hA7;
	localparam logic [7:0] OP_BIT_SET_R = 8'h76;
	localparam logic [7:0] OP_BIT_SET_P = 8'hA6;
	localparam logic [7:0] OP_SP_LOAD = 8'hFD;
	localparam logic [7:0] OP_FLAGS_LOAD = 8'hF0;
	// Condition codes (low nibble of 01..0F)
	localparam logic [3:0] CC_NEG = 4'h1;
	localparam logic [3:0] CC_ZERO = 4'h2;
	localparam logic [3:0] CC_CARRY = 4'h3;
	localparam logic [3:0] CC_POS = 4'h4;
	localparam logic [3:0] CC_POS_ZERO = 4'h5;
	localparam logic [3:0] CC_NONZERO = 4'h6;
	localparam logic [3:0] CC_NO_CARRY = 4'h7;
	localparam logic [3:0] CC_OVF = 4'h8;
	localparam logic [3:0] CC_LT = 4'h9;
	localparam logic [3:0] CC_LE = 4'hA;
	localparam logic [3:0] CC_HS = 4'hB;
	localparam logic [3:0] CC_NO_OVF = 4'hC;
	localparam logic [3:0] CC_GE = 4'hD;
	localparam logic [3:0] CC_GT = 4'hE;
	localparam logic [3:0] CC_LO = 4'hF;
	// Cycle counts
	localparam int CNT_W = 5;
	localparam logic [4:0] CYC_CPL_AB = 5'h08;
	localparam logic [4:0] CYC_CPL_FREG = 5'h06;
	localparam logic [4:0] CYC_SJ = 5'h07;
	localparam logic [4:0] CYC_LJ_DIR = 5'h09;
	localparam logic [4:0] CYC_LJ_IND = 5'h08;
	localparam logic [4:0] CYC_LJ_IDX = 5'h0B;
	localparam logic [4:0] CYC_LJ_OFS = 5'h10;
	localparam logic [4:0] CYC_JCND = 5'h05;
	localparam logic [4:0] CYC_BIT_R = 5'h0A;
	localparam logic [4:0] CYC_BIT_P = 5'h0B;
	localparam logic [4:0] CYC_TAKEN_EXTRA = 5'h02;
	localparam logic [4:0] CYC_SP_LOAD = 5'h07;
	localparam logic [4:0] CYC_FLAGS_LOAD = 5'h06;
	localparam logic [4:0] CYC_ILLEGAL = 5'h01;
	// Flags register layout
	localparam int FL_C = 7;
	localparam int FL_N = 6;
	localparam int FL_Z = 5;
	localparam int FL_V = 4;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] SP_RST = 8'h01;
	// Write destinations
	localparam logic [1:0] DST_A = 2'h0;
	localparam logic [1:0] DST_B = 2'h1;
	localparam logic [1:0] DST_FREG = 2'h2;
	// APB map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_PC = 8'h08;
	localparam logic [7:0] ADDR_SP = 8'h0C;
	localparam int CTRL_EN = 0;
	localparam int STAT_BUSY = 0;
	localparam int STAT_ILL = 1;
	localparam int STAT_TAKEN = 2;
	localparam int STAT_FL_LSB = 8;
	localparam logic CTRL_EN_RST = 1'b1;
endpackage : cjil_pkg
